/* logic/ecs_ctrl_port.v */
/*
 * ecs_ctrl_port.v - external control connector logic: edge inputs
 * for output on/off and the step sequencer, and the status outputs.
 * assumes a 50 MHz clk, active-low async resetn, and a simple register
 * port with read data valid the cycle after the read strobe.
 */
`timescale 1ns/100ps
`include "ecs_defs.vh"
`default_nettype none

module ecs_ctrl_port #(
  parameter [21:0] RESP_CYC   = `ECS_RESP_CYC,
  parameter [21:0] SETTLE_CYC = `ECS_SETTLE_CYC
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       out_off_n,
  input  wire       out_on_n,
  input  wire       seq_start_n,
  input  wire       seq_stop_n,
  input  wire       seq_hold_n,
  input  wire       branch_trig0_n,
  input  wire       branch_trig1_n,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_r,
  output reg        power_stat_r,
  output reg        out_stat_r,
  output reg        limit_stat_r,
  output reg        busy_stat_r,
  output reg        sync_code0_r,
  output reg        sync_code1_r,
  output reg        relay_on_r
);

  // sequencer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  // pending function codes held over the response latency
  localparam [6:0] F_OFF   = 7'h01;
  localparam [6:0] F_ON    = 7'h02;
  localparam [6:0] F_START = 7'h04;
  localparam [6:0] F_STOP  = 7'h08;
  localparam [6:0] F_HOLD  = 7'h10;
  localparam [6:0] F_BR0   = 7'h20;
  localparam [6:0] F_BR1   = 7'h40;

  reg        rst_m_r;
  reg        rst_n_r;
  wire       rst_n = rst_n_r;

  wire [6:0] fall;
  reg  [6:0] pend_r;
  reg  [6:0] fire_r;
  wire       resp_busy;
  wire       resp_done;
  wire       settle_busy;
  wire       settle_done;
  reg        settle_go_r;
  reg        settle_on_r;

  reg        out_en_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [7:0] step_r;
  reg  [7:0] step_nxt;
  reg  [7:0] branch_target_zero_r;
  reg  [7:0] branch_target_one_r;
  reg        mains_r;
  reg        limit_r;
  reg  [1:0] code_r;
  reg  [6:0] last_fn_r;

  // reset release through two flops; assert stays asynchronous
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // one synchroniser per pin; the controller asks by falling edges
  ecs_in_sync u_s_off (.clk(clk), .rst_n(rst_n), .pin_n(out_off_n),
                       .fall_r(fall[0]));
  ecs_in_sync u_s_on  (.clk(clk), .rst_n(rst_n), .pin_n(out_on_n),
                       .fall_r(fall[1]));
  ecs_in_sync u_s_sta (.clk(clk), .rst_n(rst_n), .pin_n(seq_start_n),
                       .fall_r(fall[2]));
  ecs_in_sync u_s_sto (.clk(clk), .rst_n(rst_n), .pin_n(seq_stop_n),
                       .fall_r(fall[3]));
  ecs_in_sync u_s_hld (.clk(clk), .rst_n(rst_n), .pin_n(seq_hold_n),
                       .fall_r(fall[4]));
  ecs_in_sync u_s_b0  (.clk(clk), .rst_n(rst_n), .pin_n(branch_trig0_n),
                       .fall_r(fall[5]));
  ecs_in_sync u_s_b1  (.clk(clk), .rst_n(rst_n), .pin_n(branch_trig1_n),
                       .fall_r(fall[6]));

  // response latency timer, started by the first edge of a batch
  ecs_delay #(.COUNT(RESP_CYC)) u_resp (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  ((|fall) & ~resp_busy),
    .busy   (resp_busy),
    .done_r (resp_done)
  );

  // relay settle timer for output on/off
  ecs_delay #(.COUNT(SETTLE_CYC)) u_settle (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (settle_go_r),
    .busy   (settle_busy),
    .done_r (settle_done)
  );

  // collect edges; all pending functions fire together when the
  // latency expires, so the worst-case response stays bounded
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 7'h00;
      fire_r <= 7'h00;
    end else begin
      fire_r <= 7'h00;
      if (resp_done) begin
        fire_r <= pend_r | fall;
        pend_r <= 7'h00;
      end else begin
        pend_r <= pend_r | fall;
      end
    end
  end

  // output on/off: off wins a tie, then the relay settles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_go_r <= 1'b0;
      settle_on_r <= 1'b0;
      out_en_r    <= 1'b0;
    end else begin
      settle_go_r <= 1'b0;
      if (fire_r[0]) begin
        settle_go_r <= 1'b1;
        settle_on_r <= 1'b0;
      end else if (fire_r[1]) begin
        settle_go_r <= 1'b1;
        settle_on_r <= 1'b1;
      end
      if (settle_done) begin
        out_en_r <= settle_on_r;
      end
    end
  end

  // sequencer next state; stop beats hold, and hold beats start only while running
  always @* begin
    state_nxt = state_r;
    step_nxt  = step_r;
    if (!out_en_r) begin
      state_nxt = ST_IDLE;
    end else if (fire_r[3]) begin
      state_nxt = ST_IDLE;
    end else if (fire_r[4] && state_r == ST_RUN) begin
      state_nxt = ST_HOLD;
    end else if (fire_r[2]) begin
      state_nxt = ST_RUN;
      if (state_r == ST_IDLE) begin
        step_nxt = `ECS_STEP_FIRST;
      end
    end
    // branches need a live sequence and a nonzero target
    if (out_en_r && state_r != ST_IDLE) begin
      if (fire_r[5] && branch_target_zero_r != 8'h00) begin
        step_nxt = branch_target_zero_r;
      end else if (fire_r[6] && branch_target_one_r != 8'h00) begin
        step_nxt = branch_target_one_r;
      end
    end
    // software steps the program while running
    if (state_nxt == ST_RUN && state_r == ST_RUN && reg_wr &&
        reg_addr == `ECS_REG_CTRL) begin
      if (reg_wdata[`ECS_CTRL_END]) begin
        state_nxt = ST_IDLE;
      end else if (reg_wdata[`ECS_CTRL_ADV]) begin
        step_nxt = step_r + 8'd1;
      end
    end
  end

  // sequencer registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      step_r  <= `ECS_STEP_RST;
    end else begin
      case (state_nxt)
        ST_IDLE: state_r <= ST_IDLE;
        ST_RUN:  state_r <= ST_RUN;
        ST_HOLD: state_r <= ST_HOLD;
        default: state_r <= ST_IDLE;
      endcase
      step_r <= step_nxt;
    end
  end

  // software-written settings and last-fired log
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      branch_target_zero_r <= `ECS_BRANCH_RST;
      branch_target_one_r  <= `ECS_BRANCH_RST;
      mains_r   <= 1'b0;
      limit_r   <= 1'b0;
      code_r    <= 2'b00;
      last_fn_r <= 7'h00;
    end else begin
      if (fire_r != 7'h00) begin
        last_fn_r <= fire_r;
      end
      if (reg_wr) begin
        case (reg_addr)
          `ECS_REG_CTRL: begin
            mains_r <= reg_wdata[`ECS_CTRL_MAINS];
            limit_r <= reg_wdata[`ECS_CTRL_LIMIT];
            code_r  <= reg_wdata[`ECS_CTRL_CODE_HI:`ECS_CTRL_CODE_LO];
          end
          `ECS_REG_TGT_ZERO: branch_target_zero_r <= reg_wdata;
          `ECS_REG_TGT_ONE:  branch_target_one_r  <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // read port; unmapped addresses read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ECS_REG_CTRL:    reg_rdata_r <= {2'b00, code_r, 2'b00,
                                          limit_r, mains_r};
        `ECS_REG_TGT_ZERO: reg_rdata_r <= branch_target_zero_r;
        `ECS_REG_TGT_ONE:  reg_rdata_r <= branch_target_one_r;
        `ECS_REG_STATUS:  reg_rdata_r <= {3'b000, settle_busy,
                                          busy_stat_r, state_r[2],
                                          state_r[1], out_en_r};
        `ECS_REG_STEP:    reg_rdata_r <= step_r;
        `ECS_REG_LAST:    reg_rdata_r <= {1'b0, last_fn_r};
        default:          reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // status pins, all registered; code shows while running or holding
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_stat_r <= 1'b0;
      out_stat_r   <= 1'b0;
      limit_stat_r <= 1'b0;
      busy_stat_r  <= 1'b0;
      sync_code0_r <= 1'b0;
      sync_code1_r <= 1'b0;
      relay_on_r   <= 1'b0;
    end else begin
      power_stat_r <= mains_r;
      out_stat_r   <= out_en_r;
      limit_stat_r <= limit_r & out_en_r;
      // busy also spans the hand-over cycles between the two timers,
      // so a waiting controller never sees a false quiet gap
      busy_stat_r  <= resp_busy | resp_done | (|fire_r) |
                      settle_go_r | settle_busy | settle_done;
      sync_code0_r <= code_r[0] & ~state_r[0];
      sync_code1_r <= code_r[1] & ~state_r[0];
      relay_on_r   <= out_en_r;
    end
  end

endmodule

`default_nettype wire

/* logic/ecs_defs.vh */
/*
 * ecs_defs.vh - constants for the external control port sequencer:
 * register offsets, field positions, reset values and timing counts.
 * assumes a 50 MHz system clock; definitions only, no logic.
 */
`ifndef ECS_DEFS_VH
`define ECS_DEFS_VH

// register indices on the plain register port (4-bit address)
`define ECS_ADDR_W          4
`define ECS_REG_CTRL        4'h0
`define ECS_REG_TGT_ZERO    4'h1
`define ECS_REG_TGT_ONE     4'h2
`define ECS_REG_STATUS      4'h3
`define ECS_REG_STEP        4'h4
`define ECS_REG_LAST        4'h5

// control register fields
`define ECS_CTRL_MAINS      0
`define ECS_CTRL_LIMIT      1
`define ECS_CTRL_ADV        2
`define ECS_CTRL_END        3
`define ECS_CTRL_CODE_LO    4
`define ECS_CTRL_CODE_HI    5

// status register fields
`define ECS_ST_OUT_ON       0
`define ECS_ST_RUN          1
`define ECS_ST_HOLD         2
`define ECS_ST_BUSY         3
`define ECS_ST_SETTLE       4

// reset values
`define ECS_BRANCH_RST      8'h00
`define ECS_STEP_FIRST      8'h01
`define ECS_STEP_RST        8'h00

// timing: response latency and relay settle, in microseconds
`define ECS_CLK_MHZ         50
`define ECS_RESP_US         50000
`define ECS_SETTLE_US       50000
// cycle counts at 50 MHz, sized to the 22-bit timer so nothing is cut
`define ECS_RESP_CYC        22'h26_25a0
`define ECS_SETTLE_CYC      22'h26_25a0
`define ECS_CNT_W           22

`endif

/* logic/ecs_in_sync.v */
/*
 * ecs_in_sync.v - two-flop synchroniser and falling-edge detector for
 * one active-low control pin.
 * assumes the pin is asynchronous to clk and idles high.
 */
`timescale 1ns/100ps
`default_nettype none

module ecs_in_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire pin_n,
  output reg  fall_r
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // reset to high, so a pin held low at reset gives one falling edge after release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      meta_r <= pin_n;
      sync_r <= meta_r;
      last_r <= sync_r;
      fall_r <= last_r & ~sync_r;
    end
  end

endmodule

`default_nettype wire

/* logic/ecs_delay.v */
/*
 * ecs_delay.v - one-shot countdown: a start pulse loads the count,
 * done pulses for one cycle when it expires.
 * assumes start is a one-cycle pulse from the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ecs_delay #(
  parameter [21:0] COUNT = 22'd1
) (
  input  wire clk,
  input  wire rst_n,
  input  wire start,
  output wire busy,
  output reg  done_r
);

  reg [21:0] cnt_r;

  // a new start restarts the wait; the newest request wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 22'h00_0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= COUNT;
      end else if (cnt_r != 22'h00_0000) begin
        cnt_r  <= cnt_r - 22'd1;
        done_r <= (cnt_r == 22'd1);
      end
    end
  end

  assign busy = (cnt_r != 22'h00_0000);

endmodule

`default_nettype wire

/* tb/ecs_port_chk_assertions.sv */
/* checker for the control port: relations between its status pins.
   assumes one clock and the raw active-low reset of the top module. */
`timescale 1ns/100ps
`default_nettype none
module ecs_port_chk #(
  parameter [21:0] RESP_CYC   = 22'd20,
  parameter [21:0] SETTLE_CYC = 22'd20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic out_on_n,
  input wire logic reg_wr,
  input wire logic power_stat_r,
  input wire logic out_stat_r,
  input wire logic limit_stat_r,
  input wire logic busy_stat_r,
  input wire logic sync_code0_r,
  input wire logic sync_code1_r,
  input wire logic relay_on_r
);
  logic [23:0] busy_cnt_r;

  // length of the busy stretch; a timer that never expires shows here
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_r <= 24'h00_0000;
    end else begin
      busy_cnt_r <= busy_stat_r ? busy_cnt_r + 24'h00_0001 : 24'h00_0000;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_relay_follows: assert property (relay_on_r == out_stat_r)
    else $error("relay and output status differ");
  a_on_busy: assert property ($fell(out_on_n) |-> ##[1:10] busy_stat_r)
    else $error("no busy after output-on request");
  a_on_settled: assert property ($rose(out_stat_r) |-> $past(busy_stat_r))
    else $error("output on without settling");
  a_off_settled: assert property ($fell(out_stat_r) |-> $past(busy_stat_r))
    else $error("output off without settling");
  a_idle_code: assert property (!out_stat_r [*3] |->
    !sync_code0_r && !sync_code1_r) else $error("code shown with output off");
  a_busy_bounded: assert property (
    busy_cnt_r <= RESP_CYC + SETTLE_CYC + 24'h00_0010)
    else $error("busy longer than latency");
  a_limit_gated: assert property (
    limit_stat_r |-> out_stat_r || $fell(out_stat_r))
    else $error("limiter shown with output off");
  a_power_write: assert property (
    $changed(power_stat_r) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("power status moved without a write");

  c_out_on: cover property ($rose(out_stat_r));
  c_code: cover property ($rose(sync_code1_r));
  c_limit: cover property ($rose(limit_stat_r));
endmodule

bind ecs_ctrl_port ecs_port_chk #(
  .RESP_CYC  (RESP_CYC),
  .SETTLE_CYC(SETTLE_CYC)
) ecs_port_chk_i (
  .clk(clk), .resetn(resetn), .out_on_n(out_on_n), .reg_wr(reg_wr),
  .power_stat_r(power_stat_r), .out_stat_r(out_stat_r),
  .limit_stat_r(limit_stat_r), .busy_stat_r(busy_stat_r),
  .sync_code0_r(sync_code0_r), .sync_code1_r(sync_code1_r),
  .relay_on_r(relay_on_r)
);
`default_nettype wire

/* tb/ecs_ctl_drv.sv */
/* model of the external controller on the control connector pins.
   assumes pins idle high through pull-ups; changes follow clk edges. */
`timescale 1ns/100ps
`default_nettype none
module ecs_ctl_drv (
  input  wire logic  clk,
  output logic [6:0] pin_n
);
  // pins idle high, as the connector pull-ups hold them
  initial begin
    pin_n = 7'h7f;
  end

  // held low for several cycles so the synchroniser cannot miss it
  task automatic pulse(input int idx);
    @(posedge clk);
    pin_n[idx] <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n[idx] <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/ecs_ctrl_port_test.sv */
/* self-checking bench for the control port with a controller model.
   assumes timer parameters shortened to 20 cycles. */
`timescale 1ns/100ps
`default_nettype none
module ecs_ctrl_port_test;
  logic       clk;
  logic       resetn;
  logic       reg_wr;
  logic       reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] d;
  wire  [7:0] rdata;
  wire  [6:0] pin_n;
  wire  [7:0] st;
  int         n_errors;
  int         checked;

  ecs_ctrl_port #(.RESP_CYC(22'd20), .SETTLE_CYC(22'd20)) ecs_ctrl_port_i (
    .clk(clk), .resetn(resetn), .out_off_n(pin_n[0]), .out_on_n(pin_n[1]),
    .seq_start_n(pin_n[2]), .seq_stop_n(pin_n[3]), .seq_hold_n(pin_n[4]),
    .branch_trig0_n(pin_n[5]), .branch_trig1_n(pin_n[6]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(rdata), .power_stat_r(st[0]),
    .out_stat_r(st[1]), .limit_stat_r(st[2]), .busy_stat_r(st[3]),
    .sync_code0_r(st[4]), .sync_code1_r(st[5]), .relay_on_r(st[6]));
  ecs_ctl_drv ecs_ctl_drv_i (.clk(clk), .pin_n(pin_n));
  assign st[7] = 1'b0;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // busy covers latency and settling, so its fall marks completion
  task automatic quiet;
    int k;
    for (k = 0; k < 300 && st[3] !== 1'b0; k++) @(posedge clk) #1;
    if (k == 300) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic act(input int idx);
    ecs_ctl_drv_i.pulse(idx);
    quiet();
  endtask

  task automatic s_idle;
    #1 chk("pins", 8'h00, st);
    rd(4'hf);
    chk("unmapped", 8'h00, d);
    wr(4'h0, 8'h03);
    repeat (3) @(posedge clk);
    #1 chk("pins", 8'h01, st);
  endtask

  task automatic s_on;
    act(2);
    rd(4'h3);
    chk("run", 8'h00, d & 8'h06);
    ecs_ctl_drv_i.pulse(1);
    #1 chk("busy", 8'h08, st & 8'h08);
    quiet();
    chk("pins", 8'h47, st);
    rd(4'h3);
    chk("status", 8'h01, d & 8'h19);
  endtask

  task automatic s_seq;
    wr(4'h0, 8'h23);
    repeat (2) @(posedge clk);
    #1 chk("pins", 8'h47, st);
    act(2);
    rd(4'h3);
    chk("run", 8'h02, d & 8'h06);
    rd(4'h4);
    chk("step", 8'h01, d);
    chk("pins", 8'h67, st);
    rd(4'h0);
    chk("ctrl", 8'h23, d);
    // software advance while running moves one step on
    wr(4'h0, 8'h27);
    rd(4'h4);
    chk("step", 8'h02, d);
  endtask

  task automatic s_branch;
    wr(4'h1, 8'h00);
    act(5);
    rd(4'h4);
    chk("step", 8'h02, d);
    wr(4'h2, 8'h05);
    rd(4'h2);
    chk("target", 8'h05, d);
    act(6);
    rd(4'h4);
    chk("step", 8'h05, d);
    wr(4'h1, 8'hff);
    act(5);
    rd(4'h4);
    chk("step", 8'hff, d);
  endtask

  task automatic s_end;
    act(4);
    rd(4'h3);
    chk("hold", 8'h04, d & 8'h06);
    // start from hold resumes at the same step
    act(2);
    rd(4'h4);
    chk("step", 8'hff, d);
    // software end while running drops to idle
    wr(4'h0, 8'h2b);
    rd(4'h3);
    chk("end", 8'h00, d & 8'h06);
    act(2);
    rd(4'h3);
    chk("run", 8'h02, d & 8'h06);
    act(3);
    rd(4'h3);
    chk("idle", 8'h00, d & 8'h06);
    rd(4'h5);
    chk("last", 8'h08, d);
    act(0);
    chk("pins", 8'h01, st);
  endtask

  // reset for 20 cycles, then the scenarios in order
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    n_errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    s_idle();
    s_on();
    s_seq();
    s_branch();
    s_end();
    give_verdict();
  end
endmodule
`default_nettype wire
